// ===== acp_core.sv
// Calibration sequencer, coefficient store and result scaling
`timescale 1ns/1ps
module acp_core #(
    parameter int NS = acp_pkg::NSETUP
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    // Converter side
    input wire logic i_raw_vld,
    input wire logic [23:0] i_raw,
    input wire logic i_fault,
    input wire logic i_ref_missing,
    // Front end steering and status
    output logic o_route_int_fs,
    output logic o_tie_inputs,
    output logic o_range_x2,
    output logic o_data_ready_n,
    output logic o_pending,
    output logic [3:0] o_filter_type,
    output logic [10:0] o_rate_divider
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic err_en;
        logic conv_err;
        logic ref_err;
        logic range_x2;
        logic [NS-1:0][15:0] filt;
        logic [NS-1:0][23:0] ofs;
        logic [NS-1:0][23:0] gain;
        logic [23:0] data;
        acp_pkg::acp_st_t st;
        acp_pkg::acp_mode_t mode;
        logic [1:0] rep;
        logic [31:0] cnt;
        logic pend;
        logic rdy_n;
    } acp_state_t;

    acp_state_t s_r;
    acp_state_t s_nxt;
    logic [acp_pkg::SW-1:0] sel;
    logic [3:0] ftype;
    logic [10:0] fsv;
    logic [31:0] fconv;
    logic signed [25:0] diff;
    logic signed [51:0] prod;
    logic signed [51:0] scaled;
    logic [23:0] sat;
    logic cal_on;
    logic [4:0] ridx;

    assign sel = s_r.ctrl[acp_pkg::CTRL_SETUP_LO +: acp_pkg::SW];
    assign ftype = s_r.filt[sel][15:12];
    assign cal_on = (s_r.st == acp_pkg::ACP_S_CAL);
    assign ridx = i_addr[4:0];

    // Rate divider per filter; sinc4 types clamp at ten
    always_comb begin
        fsv = s_r.filt[sel][10:0];
        if (ftype < 4'h2 && fsv > acp_pkg::DIV_SINC4_MAX) begin
            fsv = acp_pkg::DIV_SINC4_MAX; // R18
        end
        if (fsv == 11'h000) begin
            fsv = 11'h001;
        end
        if (ftype >= acp_pkg::FT_POST) begin
            fconv = acp_pkg::POST_FCONV; // R18
        end else begin
            fconv = 32'(acp_pkg::FCONV_PER_DIV) * 32'(fsv); // R18
        end
    end

    // Offset removal and gain scaling, shared by both codings
    always_comb begin
        diff = 26'($signed({2'b00, i_raw}))
            - 26'($signed({2'b00, s_r.ofs[sel]}))
            + 26'($signed({2'b00, acp_pkg::OFS_RST})); // R2 R3
        prod = 52'(diff) * 52'($signed({1'b0, s_r.gain[sel]}));
        if (s_r.ctrl[acp_pkg::CTRL_BIP]) begin
            scaled = (prod >>> acp_pkg::GAIN_SHIFT)
                + 52'($signed({1'b0, acp_pkg::MID})); // R3
        end else begin
            scaled = (prod >>> acp_pkg::GAIN_SHIFT) <<< 1; // R2
        end
        // Clamp rather than wrap so a large error cannot flip sign
        if (scaled < 0) begin
            sat = 24'h000000; // R24
        end else if (scaled > 52'sh0FFFFFF) begin
            sat = 24'hFFFFFF; // R24
        end else begin
            sat = scaled[23:0];
        end
    end

    // Next-state for registers, sequencer and coefficient updates
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rdy_n = s_r.rdy_n;
        // Register reads answer one cycle later
        if (i_rd) begin
            case (i_addr)
                acp_pkg::A_STAT: s_nxt.rdata = {30'h0, s_r.pend, s_r.rdy_n};
                acp_pkg::A_CTRL: s_nxt.rdata = s_r.ctrl;
                acp_pkg::A_DATA: s_nxt.rdata = {8'h00, s_r.data};
                acp_pkg::A_ERREN: s_nxt.rdata = {31'h0, s_r.err_en};
                acp_pkg::A_ERR: s_nxt.rdata = {30'h0, s_r.ref_err,
                    s_r.conv_err};
                acp_pkg::A_MISC: s_nxt.rdata = {31'h0, s_r.range_x2};
                default: begin
                    // Gain bank sits at bit 3, so index by the low bits
                    if ({2'b00, ridx[2:0]} < 5'(NS)
                        && i_addr[7:5] == 3'b001 && !cal_on) begin
                        // Coefficients hidden while calibrating
                        if (i_addr[3]) begin
                            s_nxt.rdata = {8'h00,
                                s_r.gain[ridx[2:0]]}; // R4 R5
                        end else begin
                            s_nxt.rdata = {8'h00,
                                s_r.ofs[ridx[2:0]]}; // R4 R5
                        end
                    end else if (i_addr[7:3] == 5'b00011
                        && ridx[2:0] < 3'(NS)) begin
                        s_nxt.rdata = {16'h0, s_r.filt[ridx[2:0]]};
                    end
                end
            endcase
        end
        // Writes
        if (i_wr) begin
            case (i_addr)
                acp_pkg::A_ERREN: s_nxt.err_en = i_wdata[0];
                acp_pkg::A_MISC: s_nxt.range_x2 = i_wdata[0];
                acp_pkg::A_ERR: begin
                    // Write one to clear
                    s_nxt.conv_err = s_r.conv_err & ~i_wdata[0];
                    s_nxt.ref_err = s_r.ref_err & ~i_wdata[1];
                end
                acp_pkg::A_CTRL: begin
                    s_nxt.ctrl = i_wdata;
                    if (!cal_on) begin
                        case (i_wdata[acp_pkg::CTRL_MODE_LO +: 4])
                            4'h5, 4'h6, 4'h7, 4'h8: begin
                                s_nxt.st = acp_pkg::ACP_S_CAL; // R20
                                s_nxt.mode = acp_pkg::acp_mode_t'(
                                    i_wdata[acp_pkg::CTRL_MODE_LO +: 4]);
                                s_nxt.pend = 1'b1; // R21
                                s_nxt.rdy_n = 1'b1; // R21
                                s_nxt.cnt = 32'h0;
                                s_nxt.rep = 2'h0;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: begin
                    if ({2'b00, ridx[2:0]} < 5'(NS)
                        && i_addr[7:5] == 3'b001 && !cal_on) begin
                        if (i_addr[3]) begin
                            s_nxt.gain[ridx[2:0]] = i_wdata[23:0]; // R4 R5
                        end else begin
                            s_nxt.ofs[ridx[2:0]] = i_wdata[23:0]; // R4 R5
                        end
                    end else if (i_addr[7:3] == 5'b00011
                        && ridx[2:0] < 3'(NS)) begin
                        s_nxt.filt[ridx[2:0]] = i_wdata[15:0]; // R18
                    end
                end
            endcase
        end
        // Background checks; a fault beats a same-cycle clear
        if (cal_on && s_r.err_en && i_fault) begin
            s_nxt.conv_err = 1'b1; // R6
        end
        if (cal_on && i_ref_missing) begin
            s_nxt.ref_err = 1'b1;
        end
        // Sequencer
        case (s_r.st)
            acp_pkg::ACP_S_IDLE: begin
                if (i_raw_vld) begin
                    s_nxt.data = sat; // R2 R3
                    s_nxt.rdy_n = 1'b0;
                end
            end
            acp_pkg::ACP_S_CAL: begin
                s_nxt.cnt = s_r.cnt + 32'h1;
                if (s_r.cnt + 32'h1 >= fconv) begin
                    s_nxt.cnt = 32'h0;
                    if (s_r.mode == acp_pkg::ACP_M_IFS &&
                        s_r.rep != 2'(acp_pkg::IFS_REPEAT - 1)) begin
                        s_nxt.rep = s_r.rep + 2'h1; // R12
                    end else begin
                        s_nxt.st = acp_pkg::ACP_S_DONE; // R13 R14 R15
                    end
                end
            end
            acp_pkg::ACP_S_DONE: begin
                case (s_r.mode)
                    acp_pkg::ACP_M_IZS, acp_pkg::ACP_M_SZS:
                        // Biased so the scaler's offset removal cancels it
                        s_nxt.ofs[sel] = 24'(i_raw + acp_pkg::OFS_RST); // R25
                    acp_pkg::ACP_M_IFS, acp_pkg::ACP_M_SFS: begin
                        // Gain to map measured level to full scale
                        if (i_raw > acp_pkg::MID) begin
                            s_nxt.gain[sel] = 24'(
                                (48'h1 << 46)
                                / 48'({24'h0, i_raw - acp_pkg::MID}
                                << 1)); // R25
                        end
                    end
                    default: begin
                    end
                endcase
                s_nxt.pend = 1'b0; // R21
                s_nxt.rdy_n = 1'b0; // R21
                s_nxt.mode = acp_pkg::ACP_M_IDLE;
                s_nxt.st = acp_pkg::ACP_S_IDLE;
            end
            default: s_nxt.st = acp_pkg::ACP_S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r.rdata <= 32'h0000_0000;
            s_r.ctrl <= acp_pkg::CTRL_RST;
            s_r.err_en <= 1'b0;
            s_r.conv_err <= 1'b0;
            s_r.ref_err <= 1'b0;
            s_r.range_x2 <= 1'b0;
            s_r.filt <= {NS{acp_pkg::FILT_RST}};
            s_r.ofs <= {NS{acp_pkg::OFS_RST}}; // R22
            s_r.gain <= {NS{acp_pkg::GAIN_RST}}; // R11
            s_r.data <= 24'h000000;
            s_r.st <= acp_pkg::ACP_S_IDLE;
            s_r.mode <= acp_pkg::ACP_M_IDLE;
            s_r.rep <= 2'h0;
            s_r.cnt <= 32'h0;
            s_r.pend <= 1'b0;
            s_r.rdy_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Output flops
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_route_int_fs <= 1'b0;
            o_tie_inputs <= 1'b0;
            o_range_x2 <= 1'b0;
            o_data_ready_n <= 1'b1;
            o_pending <= 1'b0;
            o_filter_type <= 4'h2;
            o_rate_divider <= 11'h001;
        end else begin
            // Steering holds through the store cycle, where i_raw is taken
            o_route_int_fs <= s_nxt.st != acp_pkg::ACP_S_IDLE
                && s_nxt.mode == acp_pkg::ACP_M_IFS; // R8
            o_tie_inputs <= s_nxt.st != acp_pkg::ACP_S_IDLE
                && s_nxt.mode == acp_pkg::ACP_M_IZS; // R13
            o_range_x2 <= s_nxt.range_x2;
            o_data_ready_n <= s_nxt.rdy_n;
            o_pending <= s_nxt.pend;
            o_filter_type <= ftype; // R18
            o_rate_divider <= fsv; // R18
        end
    end

    assign o_rdata = s_r.rdata;

    AST_PEND_CLEARS: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        s_r.st == acp_pkg::ACP_S_DONE |=> !s_r.pend && !s_r.rdy_n)
        else $error("pending not cleared at calibration end"); // R21
    AST_START: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        $rose(cal_on) |-> s_r.pend && s_r.rdy_n)
        else $error("calibration started without pending"); // R20
    AST_ZS_RESET: assert property (@(posedge i_core_clk)
        $rose(i_arst_n) |-> s_r.ofs[0] == acp_pkg::OFS_RST)
        else $error("offset reset value wrong"); // R22
    AST_NO_COEF_READ: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        cal_on && i_rd && i_addr[7:5] == 3'b001 |=> s_r.rdata == 32'h0)
        else $error("coefficient visible during calibration"); // R4
    AST_ERR_SET: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        cal_on && s_r.err_en && i_fault |=> s_r.conv_err)
        else $error("fault not flagged"); // R6
    AST_ROUTE: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        o_route_int_fs |-> s_r.mode == acp_pkg::ACP_M_IFS)
        else $error("internal source routed outside gain cal"); // R8
    AST_TIE: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        o_tie_inputs |-> s_r.mode == acp_pkg::ACP_M_IZS
            && s_r.st != acp_pkg::ACP_S_IDLE)
        else $error("inputs tied outside offset cal"); // R13
    AST_LEN: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        cal_on |-> s_r.cnt < fconv)
        else $error("calibration counter overran period"); // R12
    AST_SAT: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        scaled < 0 |-> sat == 24'h000000)
        else $error("negative result wrapped"); // R24
endmodule

// ===== acp_front_model.sv
// Converter front-end model feeding raw codes to the post-processor
`timescale 1ns/1ps
module acp_front_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Steering from the block, requests from the bench
    input wire logic i_route_int_fs,
    input wire logic i_tie_inputs,
    input wire logic i_pending,
    input wire logic i_conv,
    input wire logic i_fault_req,
    input wire logic [23:0] i_sys,
    input wire logic i_ref_req,
    // Converter outputs
    output logic o_raw_vld,
    output logic [23:0] o_raw,
    output logic o_fault,
    output logic o_ref_missing
);
    logic [23:0] code;
    // Internal sources take over the pins while the block steers them
    assign code = i_route_int_fs ? 24'hC00000 :
        (i_tie_inputs ? 24'h000100 : i_sys);
    // One result strobe per bench request
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_raw_vld <= 1'h0;
        end else begin
            o_raw_vld <= i_conv;
        end
    end
    // Code is not held outside a result or calibration, so stale use shows
    assign o_raw = (o_raw_vld || i_pending) ? code : ~code;
    assign o_fault = i_fault_req;
    // Lost reference on bench request, so the flag path is exercised
    assign o_ref_missing = i_ref_req;
endmodule

// ===== acp_pkg.sv
// Constants, types and the rule summary for the calibration post-processor
// How it works
// R1: Host recalibrates after reference or gain change
// R2: Unipolar: offset subtract, gain scale, double
// R3: Bipolar: offset subtract, gain scale, add midscale
// R4: Coefficients accessible except during calibration
// R5: Coefficient registers are 24 bits wide
// R6: Error check enabled flags faults during calibration
// R7: Host checks reference missing after calibration
// R8: Internal full-scale routes internal voltage in
// R9: Host does full-scale first, offset preset
// R10: Host sets range doubling above 2 V
// R11: Factory gain default; no unity internal gain
// R12: Internal full-scale lasts four first conversions
// R13: Internal zero-scale ties inputs, one period
// R14: System zero-scale takes one period
// R15: System full-scale takes one period
// R16: Host orders internal then system, zero first
// R17: Host keeps system span within limits
// R18: Filter type per setup; divider sets rate
// R19: Host programs only permitted divider values
// R20: Mode codes 5 to 8 start calibrations
// R21: Pending flag set, then cleared, data ready
// R22: Zero-scale coefficients reset to 0x800000
// R23: Host enables exactly one channel
// R24: Scaled result saturates, never wraps
// R25: Calibration stores measured offset or gain
package acp_pkg;
    localparam int NSETUP = 4;
    localparam int SW = 2;
    // Register indices on the plain port
    localparam logic [7:0] A_CTRL = 8'h01;
    localparam logic [7:0] A_STAT = 8'h00;
    localparam logic [7:0] A_DATA = 8'h02;
    localparam logic [7:0] A_ERREN = 8'h03;
    localparam logic [7:0] A_ERR = 8'h04;
    localparam logic [7:0] A_MISC = 8'h05;
    localparam logic [7:0] A_SETUP = 8'h10;
    localparam logic [7:0] A_FILT = 8'h18;
    localparam logic [7:0] A_OFS = 8'h20;
    localparam logic [7:0] A_GAIN = 8'h28;
    // Control field layout
    localparam int CTRL_BIP = 0;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_SETUP_LO = 6;
    // Resets and scaling
    localparam logic [23:0] OFS_RST = 24'h800000;
    localparam logic [23:0] MID = 24'h800000;
    localparam logic [23:0] GAIN_RST = 24'h555555;
    localparam int GAIN_SHIFT = 22;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] FILT_RST = 16'h2001;
    // Calibration modes
    typedef enum logic [3:0] {
        ACP_M_IDLE = 4'h0,
        ACP_M_IZS = 4'h5,
        ACP_M_IFS = 4'h6,
        ACP_M_SZS = 4'h7,
        ACP_M_SFS = 4'h8
    } acp_mode_t;
    typedef enum logic [1:0] {
        ACP_S_IDLE = 2'b00,
        ACP_S_CAL = 2'b01,
        ACP_S_DONE = 2'b10
    } acp_st_t;
    // Filter codes at or above this value are post filters
    localparam logic [3:0] FT_POST = 4'h5;
    localparam logic [10:0] DIV_SINC4_MAX = 11'h00A;
    // First conversion length in core cycles per divider unit
    localparam int FCONV_PER_DIV = 96;
    localparam logic [31:0] POST_FCONV = 32'h0000_4000;
    localparam int IFS_REPEAT = 4;
    // Bus request and result carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } acp_bus_t;
    typedef struct packed {
        logic pend;
        logic ready_n;
        logic cal_busy;
        logic route_int_fs;
        logic tie_inputs;
        logic range_x2;
    } acp_flags_t;
endpackage

// ===== test_acp_core.sv
// Self-checking bench for the calibration post-processor
`timescale 1ns/1ps
module test_acp_core;
    logic i_core_clk = 1'h0;
    logic i_arst_n = 1'h0;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata;
    logic raw_vld, fault, ref_missing, pend, route, tie, x2, rdy_n;
    logic conv = 1'h0;
    logic fault_req = 1'h0;
    logic ref_req = 1'h0;
    logic [23:0] sys = 24'h0;
    logic [23:0] raw;
    logic [3:0] ftype;
    logic [10:0] fdiv;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    acp_core uut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .i_raw_vld(raw_vld), .i_raw(raw),
        .i_fault(fault), .i_ref_missing(ref_missing),
        .o_route_int_fs(route), .o_tie_inputs(tie), .o_range_x2(x2),
        .o_data_ready_n(rdy_n), .o_pending(pend),
        .o_filter_type(ftype), .o_rate_divider(fdiv));

    acp_front_model front (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_route_int_fs(route), .i_tie_inputs(tie), .i_pending(pend),
        .i_conv(conv), .i_fault_req(fault_req), .i_sys(sys),
        .i_ref_req(ref_req),
        .o_raw_vld(raw_vld), .o_raw(raw), .o_fault(fault),
        .o_ref_missing(ref_missing));

    // 200 MHz core clock
    always #2.5 i_core_clk = ~i_core_clk;

    task automatic give_verdict;
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // A hung wait must still end in a verdict
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        @(posedge i_core_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        #1;
        chk(o_rdata, e, what);
    endtask

    task automatic post(input logic [31:0] c, input logic [23:0] ofs,
                        input logic [23:0] g, input logic [23:0] r,
                        input logic [23:0] e);
        wr(acp_pkg::A_CTRL, c);
        wr(acp_pkg::A_OFS, {8'h00, ofs});
        wr(acp_pkg::A_GAIN, {8'h00, g});
        sys <= r;
        @(posedge i_core_clk);
        conv <= 1'h1;
        @(posedge i_core_clk);
        conv <= 1'h0;
        repeat (8) tick();
        rc(acp_pkg::A_DATA, {8'h00, e}, "scaled data");
    endtask

    // Start one calibration, probe it mid-run, time it to completion
    task automatic cal(input int s, input int m, input int len,
                       input logic [23:0] code);
        int n;
        sys <= code;
        wr(acp_pkg::A_CTRL, 32'(s * 64 + m * 4));
        n = 0;
        while (pend !== 1'h1 && n < 8) begin
            tick();
            n++;
        end
        chk({29'h0, pend, route, tie}, {29'h0, 1'b1, m == 6, m == 5},
            "steer");
        rc(acp_pkg::A_STAT, 32'h3, "busy status");
        rc(acp_pkg::A_OFS + 8'(s), 32'h0, "locked offset");
        wr(acp_pkg::A_GAIN + 8'(s), 32'h0012_3456);
        n = 6;
        while (pend === 1'h1 && n < len + 40) begin
            tick();
            n++;
        end
        chk(32'(n >= len - 1 && n <= len + 8), 32'h1, "length");
        chk({31'h0, rdy_n}, 32'h0, "ready");
        rc(acp_pkg::A_STAT, 32'h0, "idle status");
    endtask

    task automatic filt(input int s, input logic [15:0] v,
                        input logic [14:0] e);
        wr(acp_pkg::A_FILT + 8'(s), {16'h0, v});
        wr(acp_pkg::A_CTRL, 32'(s * 64));
        repeat (2) tick();
        chk({17'h0, ftype, fdiv}, {17'h0, e}, "filter");
    endtask

    initial begin
        repeat (10) @(posedge i_core_clk);
        i_arst_n <= 1'h1;
        rc(acp_pkg::A_STAT, 32'h1, "reset status");
        rc(acp_pkg::A_CTRL, 32'h0, "reset control");
        rc(8'h3F, 32'h0, "unmapped");
        chk({17'h0, ftype, fdiv}, 32'h0000_1001, "reset filter");
        for (int s = 0; s < 4; s++) begin
            rc(acp_pkg::A_OFS + 8'(s), 32'h0080_0000, "offset");
            rc(acp_pkg::A_GAIN + 8'(s), 32'h0055_5555, "gain");
            rc(acp_pkg::A_FILT + 8'(s), 32'h0000_2001, "filter");
        end
        wr(acp_pkg::A_OFS + 8'h01, 32'hFFFF_FFFF);
        rc(acp_pkg::A_OFS + 8'h01, 32'h00FF_FFFF, "width");
        // Offset back at its default before the gain step
        wr(acp_pkg::A_OFS + 8'h01, 32'h0080_0000);
        post(32'h0, 24'h800000, 24'h400000, 24'h100000, 24'h200000);
        post(32'h1, 24'h800000, 24'h400000, 24'h100000, 24'h900000);
        post(32'h0, 24'h900000, 24'h400000, 24'h300000, 24'h400000);
        post(32'h0, 24'h800000, 24'h800000, 24'h600000, 24'hFFFFFF);
        post(32'h1, 24'h800000, 24'h800000, 24'h600000, 24'hFFFFFF);
        // Single channel, gain not at unity, fresh sequence
        wr(acp_pkg::A_MISC, 32'h1);
        repeat (2) tick();
        chk({31'h0, x2}, 32'h1, "range doubling");
        cal(1, 6, 384, 24'h000000);
        rc(acp_pkg::A_GAIN + 8'h01, 32'h0080_0000, "int gain");
        ref_req <= 1'h1;
        cal(1, 5, 96, 24'h000000);
        rc(acp_pkg::A_OFS + 8'h01, 32'h0080_0100, "int offset");
        rc(acp_pkg::A_GAIN + 8'h01, 32'h0080_0000, "gain kept");
        rc(acp_pkg::A_ERR, 32'h2, "reference");
        ref_req <= 1'h0;
        wr(acp_pkg::A_ERR, 32'h2);
        wr(acp_pkg::A_ERREN, 32'h1);
        fault_req <= 1'h1;
        cal(1, 7, 96, 24'h000200);
        rc(acp_pkg::A_ERR, 32'h1, "fault flag");
        rc(acp_pkg::A_OFS + 8'h01, 32'h0080_0200, "sys offset");
        fault_req <= 1'h0;
        wr(acp_pkg::A_ERR, 32'h1);
        rc(acp_pkg::A_ERR, 32'h0, "flag cleared");
        wr(acp_pkg::A_ERREN, 32'h0);
        fault_req <= 1'h1;
        cal(1, 8, 96, 24'hD00000);
        rc(acp_pkg::A_GAIN + 8'h01, 32'h0066_6666, "sys gain");
        rc(acp_pkg::A_ERR, 32'h0, "check off");
        fault_req <= 1'h0;
        filt(2, 16'h0014, 15'h000A);
        filt(2, 16'h27FF, 15'h17FF);
        filt(3, 16'h3000, 15'h1801);
        give_verdict();
    end
endmodule
